// ---- test_tape_formatter_command_executor.sv ----
// Self-checking testbench for the tape formatter command executor.
`timescale 1ns/1ns
module test_tape_formatter_command_executor;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("Error %0t: got %h exp %h", $time, g, e); end end
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, online = 1'b0, pfail = 1'b0, init = 1'b0;
  logic id_burst_seen = 1'b0;
  logic [7:0] padr = 8'h00, rwd = 8'h00, attn = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic [5:0] dly = 6'h00, code;
  logic pready, perr, ready, ack, done, rec, go, err_bit;
  int seed = 32'hcb2b84e6;
  int n_fail = 0;
  int comparisons = 0;
  initial forever #5 clk = ~clk;
  tfce_top #(.SETTLE_DOWN_CYC(50)) DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr), .SLV_ONLINE_I(online),
    .SLV_BOT_I(1'b0), .SLV_EOT_I(1'b0), .SLV_SETTLE_DOWN_I(1'b0), .SLV_ACK_I(ack), .SLV_DONE_I(done), .SLV_RECORD_I(rec),
    .SLV_TAPE_MARK_I(1'b0), .SLV_ID_BURST_I(id_burst_seen), .SLV_REWINDING_I(rwd), .SLV_ATTN_I(attn), .POWER_FAIL_I(pfail),
    .DRIVE_UNSAFE_I(pfail), .INIT_I(init), .SLV_SEL_O(), .SLV_CMD_O(), .SLV_GO_O(go), .SLV_STOP_O(), .SLV_HALT_O(),
    .SLV_HALT_MASK_O(), .ECC_ABORT_O(), .XFER_EN_O(), .DATA_ERR_INH_O(), .DRIVE_READY_O(ready));
  tfce_slave_model MODEL (.clk_i(clk), .go_i(go), .dly_i(dly), .ack_o(ack), .done_o(done), .record_o(rec));
  function automatic logic legal(input logic [5:0] c);
    return c inside {tfce_pkg::FN_NOP, tfce_pkg::FN_RWOFF, tfce_pkg::FN_RW, tfce_pkg::FN_CLR, tfce_pkg::FN_PRESET,
      tfce_pkg::FN_ERASE, tfce_pkg::FN_WTM, tfce_pkg::FN_SPF, tfce_pkg::FN_SPR, tfce_pkg::FN_WCF, tfce_pkg::FN_WCR,
      tfce_pkg::FN_WRF, tfce_pkg::FN_RDF, tfce_pkg::FN_RDR};
  endfunction : legal
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prd;
    err_bit = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task cmd(input logic [5:0] c);
    apb(1'b1, tfce_pkg::OFF_CTRL, {26'h0, c});
    repeat (3) @(posedge clk);
  endtask : cmd
  task wait_ready(input int n);
    for (int i = 0; i < n && ready !== 1'b1; i++) @(posedge clk);
    `CHK(ready, 1'b1)
  endtask : wait_ready
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err_bit, 1'b1)
    cmd(tfce_pkg::FN_ERASE);
    wait_ready(400);
    apb(1'b0, tfce_pkg::OFF_ERR, 32'h0);
    `CHK(q[tfce_pkg::ER_NEF], 1'b1)
    pfail <= 1'b1;
    cmd(tfce_pkg::FN_CLR);
    `CHK(ready, 1'b0)
    wait_ready(400);
    apb(1'b0, tfce_pkg::OFF_STAT, 32'h0);
    `CHK({q[tfce_pkg::ST_ATA], q[tfce_pkg::ST_ERR]}, 2'h3)
    apb(1'b0, tfce_pkg::OFF_ERR, 32'h0);
    `CHK({q[tfce_pkg::ER_UNS], q[tfce_pkg::ER_NEF]}, 2'h2)
    pfail <= 1'b0;
    online <= 1'b1;
    repeat (4) @(posedge clk);
    $display("offline and clear done");
    cmd(tfce_pkg::FN_NOP);
    `CHK(ready, 1'b1)
    apb(1'b0, tfce_pkg::OFF_STAT, 32'h0);
    `CHK(q[tfce_pkg::ST_ATA], 1'b0)
    id_burst_seen <= 1'b1;
    repeat (3) @(posedge clk);
    id_burst_seen <= 1'b0;
    apb(1'b0, tfce_pkg::OFF_STAT, 32'h0);
    `CHK(q[tfce_pkg::ST_IDB], 1'b1)
    dly <= 6'h2f;
    cmd(tfce_pkg::FN_ERASE);
    `CHK(ready, 1'b0)
    wait_ready(1000);
    apb(1'b0, tfce_pkg::OFF_STAT, 32'h0);
    `CHK(q[tfce_pkg::ST_ATA], 1'b1)
    apb(1'b1, tfce_pkg::OFF_TCTL, 32'h00000fff);
    cmd(tfce_pkg::FN_PRESET);
    wait_ready(1000);
    apb(1'b0, tfce_pkg::OFF_TCTL, 32'h0);
    `CHK(q[10:0], 11'h300)
    cmd(tfce_pkg::FN_SPF);
    wait_ready(400);
    apb(1'b0, tfce_pkg::OFF_ERR, 32'h0);
    `CHK(q[tfce_pkg::ER_NEF], 1'b1)
    $display("commands done");
    for (int k = 0; k < 8; k++) begin
      cmd(tfce_pkg::FN_CLR);
      wait_ready(400);
      code = 6'($random(seed)) | 6'h01;
      dly <= 6'($random(seed));
      cmd(code);
      wait_ready(1000);
      apb(1'b0, tfce_pkg::OFF_ERR, 32'h0);
      `CHK(q[tfce_pkg::ER_ILF], !legal(code))
    end
    init <= 1'b1;
    repeat (3) @(posedge clk);
    init <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(ready, 1'b0)
    wait_ready(300);
    $display("random codes and init done");
    results;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    results;
  end
endmodule : test_tape_formatter_command_executor

// ---- tfce_pkg.sv ----
// Constants, types and helper functions for the tape formatter command executor.
//
// Functional notes
// - Six-bit code; undefined codes flagged illegal.
// - Only drive clear runs without on-line.
// - No-op clears pending, keeps ready, no attention.
// - Rewind off-line: status change, attention, ready.
// - Rewind waits settle-down only after forward motion.
// - Ready and attention after slave accepts rewind.
// - Rewind end sets status change, attention.
// - Flags low until rewind starts, then high.
// - Commands to rewinding slave wait, pending kept.
// - Drive clear resets flags, maintenance, errors, count-set.
// - Clear ready after delay; power-fail raises attention.
// - Initialize anytime: all slaves, abort correction, ready.
// - Initialize halts non-rewinding slaves; power-fail attention.
// - Read-in preset loads defaults, rewinds slave zero.
// - Erase ends with attention and ready.
// - Tape mark write sets mark flag, attention.
// - Space forward counts records, aborts on mark.
// - Past end marker space one record, count error.
// - Space reverse aborts at beginning or mark.
// - Forward read: PE blocks mark, NRZI passes.
// - Reverse read never transfers a mark.
// - Write one record, pending cleared at end.
// - Preset field values for slave, parity, format, density.
// - Space or write without count-set is nonexecutable.
package tfce_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ERR = 8'h08;
  localparam logic [7:0] OFF_MAINT = 8'h0c;
  localparam logic [7:0] OFF_FCNT = 8'h10;
  localparam logic [7:0] OFF_TCTL = 8'h14;
  // Function codes, pending bit included in bit 0.
  localparam logic [5:0] FN_NOP = 6'h01;
  localparam logic [5:0] FN_RWOFF = 6'h03;
  localparam logic [5:0] FN_RW = 6'h07;
  localparam logic [5:0] FN_CLR = 6'h09;
  localparam logic [5:0] FN_PRESET = 6'h11;
  localparam logic [5:0] FN_ERASE = 6'h15;
  localparam logic [5:0] FN_WTM = 6'h17;
  localparam logic [5:0] FN_SPF = 6'h19;
  localparam logic [5:0] FN_SPR = 6'h1b;
  localparam logic [5:0] FN_WCF = 6'h29;
  localparam logic [5:0] FN_WCR = 6'h2f;
  localparam logic [5:0] FN_WRF = 6'h31;
  localparam logic [5:0] FN_RDF = 6'h39;
  localparam logic [5:0] FN_RDR = 6'h3f;
  // Status register bit positions.
  localparam int ST_ATA = 0;
  localparam int ST_SSC = 1;
  localparam int ST_TM = 2;
  localparam int ST_IDB = 3;
  localparam int ST_PIP = 4;
  localparam int ST_SETTLE_DOWN = 5;
  localparam int ST_MOL = 6;
  localparam int ST_DRY = 7;
  localparam int ST_ERR = 8;
  localparam int ST_BOT = 9;
  localparam int ST_EOT = 10;
  localparam int ST_SLA = 11;
  localparam int ST_PFAIL = 12;
  // Error register bit positions.
  localparam int ER_ILF = 0;
  localparam int ER_NEF = 2;
  localparam int ER_FCE = 9;
  localparam int ER_UNS = 14;
  // Maintenance bit kept by clears.
  localparam int MT_KEEP = 6;
  // Tape control fields and preset values.
  localparam int TC_PAR = 3;
  localparam int TC_DEN_PE = 10;
  localparam int TC_FCS = 14;
  localparam logic [15:0] TC_WR_MASK = 16'h17ff;
  localparam logic [2:0] TC_PRE_SS = 3'h0;
  localparam logic [3:0] TC_PRE_FMT = 4'h0;
  localparam logic [2:0] TC_PRE_DEN = 3'h3;
  // Reset values and the one-record frame count.
  localparam logic [15:0] RST_TCTL = 16'h0000;
  localparam logic [15:0] RST_FCNT = 16'h0000;
  localparam logic [15:0] FCNT_ONE_REC = 16'hffff;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_READY_NS = 2000;
  localparam int T_SETTLE_DOWN_MS = 15;
  localparam int READY_CYC = (T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_DOWN_CYC = T_SETTLE_DOWN_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [20:0] READY_CNT = 21'(READY_CYC);
  // Sequencer states.
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DEFER = 6'h02,
    S_SDWAIT = 6'h04,
    S_ISSUE = 6'h08,
    S_RUN = 6'h10,
    S_TIMED = 6'h20
  } tfce_state_type;

  function automatic logic tfce_is_legal(input logic [5:0] c);
    case (c)
      FN_NOP, FN_RWOFF, FN_RW, FN_CLR, FN_PRESET, FN_ERASE, FN_WTM,
      FN_SPF, FN_SPR, FN_WCF, FN_WCR, FN_WRF, FN_RDF, FN_RDR: tfce_is_legal = 1'b1;
      default: tfce_is_legal = 1'b0;
    endcase
  endfunction : tfce_is_legal

  function automatic logic tfce_is_rewind(input logic [5:0] c);
    tfce_is_rewind = (c == FN_RW) || (c == FN_PRESET);
  endfunction : tfce_is_rewind

  function automatic logic tfce_is_reverse(input logic [5:0] c);
    tfce_is_reverse = (c == FN_SPR) || (c == FN_WCR) || (c == FN_RDR);
  endfunction : tfce_is_reverse

  function automatic logic tfce_is_space(input logic [5:0] c);
    tfce_is_space = (c == FN_SPF) || (c == FN_SPR);
  endfunction : tfce_is_space

  function automatic logic tfce_is_read(input logic [5:0] c);
    tfce_is_read = (c == FN_WCF) || (c == FN_WCR) || (c == FN_RDF) || (c == FN_RDR);
  endfunction : tfce_is_read
endpackage : tfce_pkg

// ---- tfce_slave_model.sv ----
// Behavioural transport that answers issued commands.
`timescale 1ns/1ns
module tfce_slave_model (
  // Clock, command and answer delay.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [5:0] dly_i,
  // Transport answers.
  output logic ack_o,
  output logic done_o,
  output logic record_o
);
  initial begin
    ack_o = 1'b0;
    done_o = 1'b0;
    record_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        repeat (dly_i + 2) @(posedge clk_i);
        ack_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        ack_o <= 1'b0;
        record_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        record_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        done_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule : tfce_slave_model

// ---- tfce_top.sv ----
// Command decode and sequencing for the tape formatter, with its APB register file.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module tfce_top #(
  parameter int SETTLE_DOWN_CYC = tfce_pkg::SETTLE_DOWN_CYC
) (
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Transport status inputs.
  input wire logic SLV_ONLINE_I,
  input wire logic SLV_BOT_I,
  input wire logic SLV_EOT_I,
  input wire logic SLV_SETTLE_DOWN_I,
  input wire logic SLV_ACK_I,
  input wire logic SLV_DONE_I,
  input wire logic SLV_RECORD_I,
  input wire logic SLV_TAPE_MARK_I,
  input wire logic SLV_ID_BURST_I,
  input wire logic [7:0] SLV_REWINDING_I,
  input wire logic [7:0] SLV_ATTN_I,
  // System inputs.
  input wire logic POWER_FAIL_I,
  input wire logic DRIVE_UNSAFE_I,
  input wire logic INIT_I,
  // Transport control outputs.
  output logic [2:0] SLV_SEL_O,
  output logic [5:0] SLV_CMD_O,
  output logic SLV_GO_O,
  output logic SLV_STOP_O,
  output logic SLV_HALT_O,
  output logic [7:0] SLV_HALT_MASK_O,
  output logic ECC_ABORT_O,
  output logic XFER_EN_O,
  output logic DATA_ERR_INH_O,
  output logic DRIVE_READY_O
);
  localparam logic [20:0] SETTLE_DOWN_CNT = 21'(SETTLE_DOWN_CYC);

  // Two-stage synchronisers for all transport and system inputs; stage three is edge history.
  logic [27:0] sync1_r;
  logic [27:0] sync2_r;
  logic [27:0] sync3_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      sync1_r <= 28'h0000000;
      sync2_r <= 28'h0000000;
      sync3_r <= 28'h0000000;
    end else begin
      sync1_r <= {SLV_ATTN_I, SLV_REWINDING_I, INIT_I, DRIVE_UNSAFE_I, POWER_FAIL_I, SLV_ID_BURST_I,
                  SLV_TAPE_MARK_I, SLV_RECORD_I, SLV_DONE_I, SLV_ACK_I, SLV_SETTLE_DOWN_I, SLV_EOT_I, SLV_BOT_I,
                  SLV_ONLINE_I};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic [27:0] rise;
  logic medium_online, bot, eot, settle_down, pfail;
  logic ack_p, done_p, rec_p, tm_p, idb_p, uns_p, init_p, eot_p, bot_p;
  logic [7:0] rewinding, rwd_fall, sla_rise;
  assign rise = sync2_r & ~sync3_r;
  assign medium_online = sync2_r[0];
  assign bot = sync2_r[1];
  assign eot = sync2_r[2];
  assign settle_down = sync2_r[3];
  assign pfail = sync2_r[9];
  assign rewinding = sync2_r[19:12];
  assign bot_p = rise[1];
  assign eot_p = rise[2];
  assign ack_p = rise[4];
  assign done_p = rise[5];
  assign rec_p = rise[6];
  assign tm_p = rise[7];
  assign idb_p = rise[8];
  assign uns_p = rise[10];
  assign init_p = rise[11];
  assign rwd_fall = sync3_r[19:12] & ~sync2_r[19:12];
  assign sla_rise = rise[27:20];

  // Registers and sequencer state.
  tfce_pkg::tfce_state_type st_r;
  logic go_r, ready_r, deferred_r, last_fwd_r, ack_seen_r, single_r;
  logic [5:0] cmd_r;
  logic [20:0] tmr_r;
  logic ata_r, ssc_r, tm_r, idb_r;
  logic [7:0] unit_attention_r;
  logic [15:0] err_r, maint_r, fcnt_r, tctl_r;

  logic [2:0] sel;
  logic positioning_in_progress, frame_count_loaded;
  assign sel = tctl_r[2:0];
  assign positioning_in_progress = rewinding[sel];
  assign frame_count_loaded = tctl_r[tfce_pkg::TC_FCS];

  // APB decode.
  logic wr_acc, ctrl_wr, stat_wr;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign ctrl_wr = wr_acc && (PADDR_I == tfce_pkg::OFF_CTRL);
  assign stat_wr = wr_acc && (PADDR_I == tfce_pkg::OFF_STAT);

  // Command acceptance and launch.
  logic [5:0] wcode, lcode;
  logic accept, rej_ilf, rej_nef, launch, sd_hold, issue_go, fin, stop_any, stop_single;
  assign wcode = PWDATA_I[5:0];
  assign accept = ctrl_wr && PWDATA_I[0] && ready_r && (st_r == tfce_pkg::S_IDLE) && !init_p;
  assign rej_ilf = !tfce_pkg::tfce_is_legal(wcode);
  assign rej_nef = !rej_ilf && (((wcode != tfce_pkg::FN_CLR) && !medium_online) ||
                   ((tfce_pkg::tfce_is_space(wcode) || (wcode == tfce_pkg::FN_WRF)) && !frame_count_loaded));
  assign launch = !init_p && ((accept && !rej_ilf && !rej_nef && !positioning_in_progress) ||
                  ((st_r == tfce_pkg::S_DEFER) && !positioning_in_progress));
  assign lcode = (st_r == tfce_pkg::S_DEFER) ? cmd_r : wcode;
  assign sd_hold = tfce_pkg::tfce_is_rewind(lcode) && settle_down && last_fwd_r;
  assign issue_go = (launch && (lcode != tfce_pkg::FN_NOP) && (lcode != tfce_pkg::FN_CLR) && !sd_hold) ||
                    ((st_r == tfce_pkg::S_SDWAIT) && (!settle_down || (tmr_r == 21'h000000)) && !init_p);
  assign fin = !init_p && ((st_r == tfce_pkg::S_RUN && done_p) ||
               (st_r == tfce_pkg::S_TIMED && tmr_r == 21'h000000) ||
               (st_r == tfce_pkg::S_ISSUE && (ack_p || ack_seen_r) &&
                (!tfce_pkg::tfce_is_rewind(cmd_r) || tmr_r == 21'h000000) &&
                (cmd_r == tfce_pkg::FN_RWOFF || tfce_pkg::tfce_is_rewind(cmd_r))));
  assign stop_single = (st_r == tfce_pkg::S_RUN) && (cmd_r == tfce_pkg::FN_SPF) && single_r && rec_p;
  assign stop_any = (st_r == tfce_pkg::S_RUN) && tfce_pkg::tfce_is_space(cmd_r) &&
                    ((rec_p && (fcnt_r == tfce_pkg::FCNT_ONE_REC)) || stop_single || tm_p ||
                     ((cmd_r == tfce_pkg::FN_SPF) && eot_p) || ((cmd_r == tfce_pkg::FN_SPR) && bot_p));

  // Sequencer.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      st_r <= tfce_pkg::S_IDLE;
      go_r <= 1'b0;
      cmd_r <= 6'h00;
      tmr_r <= 21'h000000;
      deferred_r <= 1'b0;
      last_fwd_r <= 1'b0;
      ack_seen_r <= 1'b0;
      single_r <= 1'b0;
    end else if (init_p) begin
      st_r <= tfce_pkg::S_TIMED;
      go_r <= 1'b0;
      tmr_r <= tfce_pkg::READY_CNT;
      deferred_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      if (tmr_r != 21'h000000) begin
        tmr_r <= 21'(tmr_r - 21'h000001);
      end
      case (st_r)
        tfce_pkg::S_IDLE, tfce_pkg::S_DEFER: begin
          if (launch) begin
            cmd_r <= lcode;
            single_r <= (lcode == tfce_pkg::FN_SPF) && eot && (fcnt_r != tfce_pkg::FCNT_ONE_REC);
            if (lcode == tfce_pkg::FN_NOP) begin
              go_r <= 1'b0;
              st_r <= tfce_pkg::S_IDLE;
              deferred_r <= 1'b0;
            end else if (lcode == tfce_pkg::FN_CLR) begin
              go_r <= 1'b1;
              st_r <= tfce_pkg::S_TIMED;
              tmr_r <= tfce_pkg::READY_CNT;
            end else begin
              go_r <= 1'b1;
              tmr_r <= sd_hold ? SETTLE_DOWN_CNT : tfce_pkg::READY_CNT;
              st_r <= sd_hold ? tfce_pkg::S_SDWAIT : tfce_pkg::S_ISSUE;
              if (!tfce_pkg::tfce_is_rewind(lcode) && (lcode != tfce_pkg::FN_RWOFF)) begin
                last_fwd_r <= !tfce_pkg::tfce_is_reverse(lcode);
              end
            end
          end else if (accept && !rej_ilf && !rej_nef) begin
            cmd_r <= wcode;
            go_r <= 1'b1;
            deferred_r <= 1'b1;
            st_r <= tfce_pkg::S_DEFER;
          end
        end
        tfce_pkg::S_SDWAIT: begin
          if (issue_go) begin
            st_r <= tfce_pkg::S_ISSUE;
          end
        end
        tfce_pkg::S_ISSUE: begin
          if (fin) begin
            go_r <= 1'b0;
            st_r <= tfce_pkg::S_IDLE;
            ack_seen_r <= 1'b0;
            deferred_r <= 1'b0;
          end else if (ack_p) begin
            if (tfce_pkg::tfce_is_rewind(cmd_r)) begin
              ack_seen_r <= 1'b1;
            end else begin
              st_r <= tfce_pkg::S_RUN;
            end
          end
        end
        tfce_pkg::S_RUN: begin
          if (done_p) begin
            go_r <= 1'b0;
            st_r <= tfce_pkg::S_IDLE;
            deferred_r <= 1'b0;
          end
        end
        tfce_pkg::S_TIMED: begin
          if (tmr_r == 21'h000000) begin
            go_r <= 1'b0;
            st_r <= tfce_pkg::S_IDLE;
          end
        end
        default: begin
          st_r <= tfce_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Drive ready.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ready_r <= 1'b1;
    end else if (init_p) begin
      ready_r <= 1'b0;
    end else if (launch && (lcode != tfce_pkg::FN_NOP)) begin
      ready_r <= 1'b0;
    end else if (fin) begin
      ready_r <= 1'b1;
    end
  end

  // Status flags; clears come first so a same-cycle set wins.
  logic clr_do, ssc_keep, ata_fin;
  assign clr_do = launch && (lcode == tfce_pkg::FN_CLR);
  assign ssc_keep = (unit_attention_r & ~(8'h01 << sel)) != 8'h00;
  assign ata_fin = fin && ((st_r != tfce_pkg::S_RUN) || deferred_r || (err_r != 16'h0000) ||
                   (cmd_r == tfce_pkg::FN_ERASE) || (cmd_r == tfce_pkg::FN_WTM) || tfce_pkg::tfce_is_space(cmd_r)) &&
                   !((st_r == tfce_pkg::S_TIMED) && !pfail);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ata_r <= 1'b0;
      ssc_r <= 1'b0;
      tm_r <= 1'b0;
      idb_r <= 1'b0;
      unit_attention_r <= 8'h00;
    end else begin
      if (accept || clr_do || init_p || (stat_wr && PWDATA_I[tfce_pkg::ST_ATA])) begin
        ata_r <= 1'b0;
      end
      if (init_p || (clr_do && !ssc_keep) || (stat_wr && PWDATA_I[tfce_pkg::ST_SSC])) begin
        ssc_r <= 1'b0;
      end
      if (clr_do || init_p) begin
        tm_r <= 1'b0;
        idb_r <= 1'b0;
      end
      if (init_p) begin
        unit_attention_r <= 8'h00;
      end else if (clr_do) begin
        unit_attention_r <= unit_attention_r & ~(8'h01 << sel);
      end
      unit_attention_r <= (init_p ? 8'h00 : clr_do ? (unit_attention_r & ~(8'h01 << sel)) : unit_attention_r) | sla_rise;
      if ((accept && (rej_ilf || rej_nef)) || ata_fin || (rwd_fall != 8'h00) || (sla_rise != 8'h00)) begin
        ata_r <= 1'b1;
      end
      if ((rwd_fall != 8'h00) || (sla_rise != 8'h00) ||
          (fin && (st_r == tfce_pkg::S_ISSUE) && ((cmd_r == tfce_pkg::FN_RWOFF) || bot))) begin
        ssc_r <= 1'b1;
      end
      if ((st_r == tfce_pkg::S_RUN) && tm_p) begin
        tm_r <= 1'b1;
      end
      if (idb_p) begin
        idb_r <= 1'b1;
      end
    end
  end

  // Error register.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      err_r <= 16'h0000;
    end else begin
      if (clr_do || init_p) begin
        err_r <= pfail ? (err_r & (16'h0001 << tfce_pkg::ER_UNS)) : 16'h0000;
      end
      if (accept && rej_ilf) begin
        err_r[tfce_pkg::ER_ILF] <= 1'b1;
      end
      if (accept && rej_nef) begin
        err_r[tfce_pkg::ER_NEF] <= 1'b1;
      end
      if (stop_single) begin
        err_r[tfce_pkg::ER_FCE] <= 1'b1;
      end
      if (uns_p || (fin && (st_r == tfce_pkg::S_TIMED) && pfail)) begin
        err_r[tfce_pkg::ER_UNS] <= 1'b1;
      end
    end
  end

  // Maintenance, frame count and tape control.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      maint_r <= 16'h0000;
      fcnt_r <= tfce_pkg::RST_FCNT;
      tctl_r <= tfce_pkg::RST_TCTL;
    end else begin
      if (wr_acc && (PADDR_I == tfce_pkg::OFF_MAINT)) begin
        maint_r <= PWDATA_I[15:0];
      end
      if (wr_acc && (PADDR_I == tfce_pkg::OFF_TCTL)) begin
        tctl_r <= (PWDATA_I[15:0] & tfce_pkg::TC_WR_MASK) | (tctl_r & ~tfce_pkg::TC_WR_MASK);
      end
      if (wr_acc && (PADDR_I == tfce_pkg::OFF_FCNT)) begin
        fcnt_r <= PWDATA_I[15:0];
        tctl_r[tfce_pkg::TC_FCS] <= 1'b1;
      end
      if (clr_do || init_p) begin
        maint_r <= maint_r & (16'h0001 << tfce_pkg::MT_KEEP);
        tctl_r[tfce_pkg::TC_FCS] <= 1'b0;
      end
      if (launch && (lcode == tfce_pkg::FN_PRESET)) begin
        tctl_r[10:0] <= {tfce_pkg::TC_PRE_DEN, tfce_pkg::TC_PRE_FMT, 1'b0, tfce_pkg::TC_PRE_SS};
      end
      if ((st_r == tfce_pkg::S_RUN) && tfce_pkg::tfce_is_space(cmd_r) && rec_p) begin
        fcnt_r <= 16'(fcnt_r + 16'h0001);
        if (fcnt_r == tfce_pkg::FCNT_ONE_REC) begin
          tctl_r[tfce_pkg::TC_FCS] <= 1'b0;
        end
      end
    end
  end

  // Transport control outputs.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      SLV_CMD_O <= 6'h00;
      SLV_GO_O <= 1'b0;
      SLV_STOP_O <= 1'b0;
      SLV_HALT_O <= 1'b0;
      SLV_HALT_MASK_O <= 8'h00;
      ECC_ABORT_O <= 1'b0;
      XFER_EN_O <= 1'b0;
      DATA_ERR_INH_O <= 1'b0;
    end else begin
      SLV_GO_O <= issue_go;
      if (issue_go) begin
        SLV_CMD_O <= (st_r == tfce_pkg::S_SDWAIT) ? cmd_r : lcode;
      end
      SLV_STOP_O <= stop_any;
      SLV_HALT_O <= init_p;
      SLV_HALT_MASK_O <= init_p ? ~rewinding : 8'h00;
      ECC_ABORT_O <= init_p;
      DATA_ERR_INH_O <= (st_r == tfce_pkg::S_RUN) && tfce_pkg::tfce_is_space(cmd_r);
      if (init_p || done_p) begin
        XFER_EN_O <= 1'b0;
      end else if ((st_r == tfce_pkg::S_ISSUE) && ack_p && tfce_pkg::tfce_is_read(cmd_r)) begin
        XFER_EN_O <= 1'b1;
      end else if (tm_p && (tfce_pkg::tfce_is_reverse(cmd_r) || tctl_r[tfce_pkg::TC_DEN_PE])) begin
        XFER_EN_O <= 1'b0;
      end
    end
  end

  // APB read data, captured in the setup cycle.
  logic mapped;
  assign mapped = (PADDR_I == tfce_pkg::OFF_CTRL) || (PADDR_I == tfce_pkg::OFF_STAT) ||
                  (PADDR_I == tfce_pkg::OFF_ERR) || (PADDR_I == tfce_pkg::OFF_MAINT) ||
                  (PADDR_I == tfce_pkg::OFF_FCNT) || (PADDR_I == tfce_pkg::OFF_TCTL);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I) begin
      case (PADDR_I)
        tfce_pkg::OFF_CTRL: PRDATA_O <= {26'h0000000, cmd_r[5:1], go_r};
        tfce_pkg::OFF_STAT: PRDATA_O <= {19'h00000, pfail, unit_attention_r[sel], eot, bot, err_r != 16'h0000,
                                         ready_r, medium_online, settle_down, positioning_in_progress,
                                         idb_r, tm_r, ssc_r, ata_r};
        tfce_pkg::OFF_ERR: PRDATA_O <= {16'h0000, err_r};
        tfce_pkg::OFF_MAINT: PRDATA_O <= {16'h0000, maint_r};
        tfce_pkg::OFF_FCNT: PRDATA_O <= {16'h0000, fcnt_r};
        tfce_pkg::OFF_TCTL: PRDATA_O <= {16'h0000, tctl_r};
        default: PRDATA_O <= 32'h00000000;
      endcase
    end
  end
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign SLV_SEL_O = sel;
  assign DRIVE_READY_O = ready_r;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  a_nop_ready: assert property (launch && lcode == tfce_pkg::FN_NOP |=> ready_r && !go_r)
    else $error("No-op did not leave ready set and pending clear.");
  a_illegal_fn: assert property (accept && rej_ilf |=> err_r[tfce_pkg::ER_ILF] && !go_r && ata_r)
    else $error("Illegal code was not flagged.");
  a_offline_flags: assert property (fin && st_r == tfce_pkg::S_ISSUE && cmd_r == tfce_pkg::FN_RWOFF
    |=> ata_r && ssc_r && ready_r && !go_r)
    else $error("Rewind off-line did not raise its flags.");
  a_bot_change: assert property ((rwd_fall != 8'h00) |=> ssc_r && ata_r)
    else $error("Rewind end did not flag a status change.");
  a_defer_hold: assert property (st_r == tfce_pkg::S_DEFER |-> go_r && ready_r && positioning_in_progress
    or ##1 st_r != tfce_pkg::S_DEFER)
    else $error("Deferred command lost its pending bit.");
  a_fcs_nef: assert property (accept && !rej_ilf && medium_online &&
    (wcode == tfce_pkg::FN_WRF) && !frame_count_loaded |=> err_r[tfce_pkg::ER_NEF] && st_r == tfce_pkg::S_IDLE)
    else $error("Write without frame count was executed.");
  a_clear_ready: assert property (disable iff (!RST_N_I || init_p) clr_do
    |=> !ready_r [*8] ##[180:205] ready_r)
    else $error("Drive clear ready timing wrong.");
  a_init_ready: assert property (disable iff (!RST_N_I) init_p |-> ##[1:205] ready_r)
    else $error("Initialize did not complete in time.");
  a_busy_ignore: assert property (ctrl_wr && !ready_r && st_r != tfce_pkg::S_DEFER |=> $stable(cmd_r))
    else $error("Command accepted while busy.");
  a_single_fce: assert property (stop_single |=> err_r[tfce_pkg::ER_FCE] ##0 SLV_STOP_O)
    else $error("Single record space did not flag count error.");
endmodule : tfce_top
